// ===== logic/vpm_pkg.sv
// Constants, register map and carrier types for the voice processor mode control bank.
// Assumes one 100 MHz clock and an APB master with 32-bit data.
// Function
// - low power-down pin clears all state, power-down bit all control registers but itself; then initial mode follows.
// - soft reset bit or low reset pin clears canceler coefficients, keeps registers, mutes.
// - bit-triggered power-down loads pin-reset values into all four registers except the power-down bit.
// - line codec disable (bit OR pin) powers codec down, floats output, idles input.
// - clock output disable floats sync and bit clock only in internal clock mode.
// - line port disable floats line serial output and idles line serial input.
// - message port disable floats message serial output and idles its input.
// - port enables, mode bits, memory strobe change only in power-down or initial mode.
// - initial mode is entered about 200 ms after power-down release.
// - initial mode floats line and message serial outputs, idles their inputs, keeps both cancelers inactive.
// - host-select high skips initial mode; valid mode leaves it; only power-down returns.
// - mode code 10 is dual canceler, 11 is single acoustic canceler, others reserved.
// - dual mode default echo delays are 44 ms acoustic and 15 ms line.
// - effective mode bits are register bits ORed with host-select and canceler-select pins.
// - memory strobe writes held data to held address, only in initial mode.
// - pad bit OR pin at 0 bypasses attenuators and amplifiers, at 1 applies them.
// - noise bypass bit OR pin at 0 runs noise canceler, at 1 passes data through.
// - leaving noise bypass causes about 20 ms of data dropout.
// - receive gain code decodes as signed 3 dB steps with a dedicated mute code.
// - transmit gain code uses the same step encoding and mute code.
package vpm_pkg;

   // register indices; byte address is four times the index
   localparam logic [1:0]  IDX_MODE     = 2'h0;
   localparam logic [1:0]  IDX_BYPASS   = 2'h1;
   localparam logic [1:0]  IDX_RX_LEVEL = 2'h2;
   localparam logic [1:0]  IDX_TX_LEVEL = 2'h3;

   localparam logic [7:0]  RST_MODE     = 8'h00;
   localparam logic [7:0]  RST_BYPASS   = 8'h00;
   localparam logic [7:0]  RST_RX_LEVEL = 8'h00;
   localparam logic [7:0]  RST_TX_LEVEL = 8'h00;

   // basic_mode_control fields
   localparam int          B_PWR_DOWN   = 7;
   localparam int          B_SOFT_RST   = 6;
   localparam int          B_LINE_DIS   = 5;
   localparam int          B_CLK_DIS    = 4;
   localparam int          B_LPORT_DIS  = 3;
   localparam int          B_MPORT_DIS  = 2;
   localparam int          B_MODE_HI    = 1;
   localparam int          B_MODE_LO    = 0;
   localparam logic [7:0]  MODE_LOCKED  = 8'h3f;

   // memory_write_and_bypass_control fields
   localparam int          B_MEM_WR     = 7;
   localparam int          B_PAD        = 2;
   localparam int          B_SLOPE      = 1;
   localparam int          B_NOISE      = 0;
   localparam logic [7:0]  BYPASS_USED  = 8'h07;

   localparam logic [7:0]  GAIN_USED    = 8'h3f;
   localparam logic [5:0]  GAIN_MUTE    = 6'h2b;

   localparam logic [1:0]  OPM_INIT     = 2'h0;
   localparam logic [1:0]  OPM_DUAL     = 2'h2;
   localparam logic [1:0]  OPM_SINGLE   = 2'h3;

   localparam logic [7:0]  DUAL_ACOUSTIC_DELAY_MS = 8'h2c;
   localparam logic [7:0]  DUAL_LINE_DELAY_MS     = 8'h0f;

   localparam int          CLK_KHZ      = 100000;
   localparam int          WAKE_MS      = 200;
   localparam int          DROPOUT_MS   = 20;
   localparam int          WAKE_CYCLES  = WAKE_MS * CLK_KHZ;
   localparam int          DROP_CYCLES  = DROPOUT_MS * CLK_KHZ;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } vpm_apb_req_t;

   typedef struct packed {
      logic              mute;
      logic signed [7:0] gain_db;
   } vpm_gain_t;

   typedef enum logic [1:0] {
      ST_PWRDN = 2'b00,
      ST_WAKE  = 2'b01,
      ST_INIT  = 2'b10,
      ST_RUN   = 2'b11
   } vpm_state_t;

endpackage

// ===== logic/vpm_mode_regs.sv
// Control register bank and operating mode sequencer of the voice processor.
// Assumes synchronous pins, an APB master on mclk_in, and memory address/data held elsewhere.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module vpm_mode_regs
#(
   parameter int WAKE_CYCLES_P = vpm_pkg::WAKE_CYCLES,
   parameter int DROP_CYCLES_P = vpm_pkg::DROP_CYCLES
)
(
   input  wire logic                 mclk_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 ce_in,
   input  wire vpm_pkg::vpm_apb_req_t apb_in,
   output logic [31:0]               prdata_out,
   output logic                      pready_out,
   output logic                      pslverr_out,
   input  wire logic                 power_down_reset_n_in,
   input  wire logic                 soft_reset_n_in,
   input  wire logic                 line_codec_disable_in,
   input  wire logic                 clock_source_select_in,
   input  wire logic                 host_select_in,
   input  wire logic                 canceler_select_in,
   input  wire logic                 pad_bypass_in,
   input  wire logic                 slope_bypass_in,
   input  wire logic                 noise_bypass_in,
   input  wire logic [15:0]          mem_addr_in,
   input  wire logic [15:0]          mem_data_in,
   output logic                      mem_wr_out,
   output logic [15:0]               mem_addr_out,
   output logic [15:0]               mem_data_out,
   output logic                      power_down_out,
   output logic                      initial_mode_out,
   output logic                      dual_mode_out,
   output logic                      single_mode_out,
   output logic [7:0]                acoustic_delay_ms_out,
   output logic [7:0]                line_delay_ms_out,
   output logic                      canceler_clear_out,
   output logic                      audio_mute_out,
   output logic                      echo_canceler_run_out,
   output logic                      noise_canceler_run_out,
   output logic                      noise_through_out,
   output logic                      noise_dropout_out,
   output logic                      line_codec_power_out,
   output logic                      line_codec_out_oe_out,
   output logic                      line_codec_in_idle_out,
   output logic                      clock_out_oe_out,
   output logic                      line_serial_out_oe_out,
   output logic                      line_serial_in_idle_out,
   output logic                      message_serial_out_oe_out,
   output logic                      message_serial_in_idle_out,
   output logic                      pads_apply_out,
   output logic                      slope_through_out,
   output vpm_pkg::vpm_gain_t        rx_gain_out,
   output vpm_pkg::vpm_gain_t        tx_gain_out
);
   import vpm_pkg::*;

   vpm_state_t  state_ff;
   vpm_state_t  nxt_state;
   logic [7:0]  mode_ff;
   logic [7:0]  bypass_ff;
   logic [7:0]  rx_level_ff;
   logic [7:0]  tx_level_ff;
   logic [31:0] wake_cnt_ff;
   logic [31:0] drop_cnt_ff;
   logic        noise_eff_prev_ff;
   logic [31:0] prdata_ff;
   logic        mem_wr_ff;
   logic [15:0] mem_addr_ff;
   logic [15:0] mem_data_ff;
   vpm_gain_t   gain_ff [2];
   logic [5:0]  gain_code [2];

   logic        pin_pd;
   logic        pd_req;
   logic        soft_rst;
   logic        in_run;
   logic        locked_open;
   logic        mapped;
   logic        wr_acc;
   logic [1:0]  idx;
   logic [1:0]  eff_mode;
   logic        noise_eff;
   logic        line_dis_eff;
   logic [31:0] rd_mux;

   // power-down from the pin reaches every bit, the bit itself keeps only itself
   assign pin_pd   = !power_down_reset_n_in;
   assign pd_req   = mode_ff[B_PWR_DOWN] | pin_pd;
   assign soft_rst = mode_ff[B_SOFT_RST] | !soft_reset_n_in;
   assign in_run   = (state_ff == ST_RUN);
   assign eff_mode = {mode_ff[B_MODE_HI] | host_select_in,
                      mode_ff[B_MODE_LO] | canceler_select_in};
   assign noise_eff    = bypass_ff[B_NOISE] | noise_bypass_in;
   assign line_dis_eff = mode_ff[B_LINE_DIS] | line_codec_disable_in;
   // locked fields are writable only while powered down by the bit or in initial mode
   assign locked_open  = (state_ff == ST_PWRDN) || (state_ff == ST_INIT);

   // apb decode: four aligned words at the bottom of the window
   assign idx     = apb_in.paddr[3:2];
   assign mapped  = (apb_in.paddr[11:4] == 8'h00) && (apb_in.paddr[1:0] == 2'h0);
   assign wr_acc  = apb_in.psel && apb_in.penable && apb_in.pwrite && mapped && ce_in;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (idx)
         IDX_MODE:     rd_mux = {24'h00_0000, mode_ff};
         IDX_BYPASS:   rd_mux = {24'h00_0000, bypass_ff & BYPASS_USED};
         IDX_RX_LEVEL: rd_mux = {24'h00_0000, rx_level_ff & GAIN_USED};
         IDX_TX_LEVEL: rd_mux = {24'h00_0000, tx_level_ff & GAIN_USED};
         default:      rd_mux = 32'h0000_0000;
      endcase
      if (!mapped)
      begin
         rd_mux = 32'h0000_0000;
      end
   end

   // read data is captured in the setup phase so it stands through the access phase
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         prdata_ff <= 32'h0000_0000;
      end
      else if (ce_in && apb_in.psel && !apb_in.penable)
      begin
         prdata_ff <= rd_mux;
      end
   end

   assign prdata_out  = prdata_ff;
   assign pready_out  = 1'b1;
   assign pslverr_out = apb_in.psel && apb_in.penable && !mapped;

   // basic_mode_control
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in || pin_pd)
      begin
         mode_ff <= RST_MODE;
      end
      else if (ce_in)
      begin
         if (mode_ff[B_PWR_DOWN] && state_ff != ST_PWRDN)
         begin
            // entry into bit power-down: initial values everywhere except the bit
            mode_ff <= RST_MODE | (8'h01 << B_PWR_DOWN);
         end
         else if (wr_acc && idx == IDX_MODE)
         begin
            mode_ff[B_PWR_DOWN] <= apb_in.pwdata[B_PWR_DOWN];
            mode_ff[B_SOFT_RST] <= apb_in.pwdata[B_SOFT_RST];
            if (locked_open)
            begin
               mode_ff[5:0] <= apb_in.pwdata[5:0] & MODE_LOCKED[5:0];
            end
         end
      end
   end

   // memory_write_and_bypass_control; the strobe bit never stores, it fires a pulse
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in || pin_pd)
      begin
         bypass_ff <= RST_BYPASS;
      end
      else if (ce_in)
      begin
         if (mode_ff[B_PWR_DOWN] && state_ff != ST_PWRDN)
         begin
            bypass_ff <= RST_BYPASS;
         end
         else if (wr_acc && idx == IDX_BYPASS)
         begin
            bypass_ff <= apb_in.pwdata[7:0] & BYPASS_USED;
         end
      end
   end

   // level registers
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in || pin_pd)
      begin
         rx_level_ff <= RST_RX_LEVEL;
         tx_level_ff <= RST_TX_LEVEL;
      end
      else if (ce_in)
      begin
         if (mode_ff[B_PWR_DOWN] && state_ff != ST_PWRDN)
         begin
            rx_level_ff <= RST_RX_LEVEL;
            tx_level_ff <= RST_TX_LEVEL;
         end
         else if (wr_acc && idx == IDX_RX_LEVEL)
         begin
            rx_level_ff <= apb_in.pwdata[7:0] & GAIN_USED;
         end
         else if (wr_acc && idx == IDX_TX_LEVEL)
         begin
            tx_level_ff <= apb_in.pwdata[7:0] & GAIN_USED;
         end
      end
   end

   // memory write strobe: one pulse carrying the address and data held at the write
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in || pin_pd)
      begin
         mem_wr_ff   <= 1'b0;
         mem_addr_ff <= 16'h0000;
         mem_data_ff <= 16'h0000;
      end
      else if (ce_in)
      begin
         mem_wr_ff <= wr_acc && (idx == IDX_BYPASS) && apb_in.pwdata[B_MEM_WR]
                      && (state_ff == ST_INIT);
         if (wr_acc && (idx == IDX_BYPASS) && apb_in.pwdata[B_MEM_WR] && (state_ff == ST_INIT))
         begin
            mem_addr_ff <= mem_addr_in;
            mem_data_ff <= mem_data_in;
         end
      end
   end

   assign mem_wr_out   = mem_wr_ff;
   assign mem_addr_out = mem_addr_ff;
   assign mem_data_out = mem_data_ff;

   // mode sequencer
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_PWRDN:
         begin
            if (!pd_req)
            begin
               nxt_state = ST_WAKE;
            end
         end
         ST_WAKE:
         begin
            if (pd_req)
            begin
               nxt_state = ST_PWRDN;
            end
            else if (wake_cnt_ff >= 32'(WAKE_CYCLES_P - 1))
            begin
               nxt_state = host_select_in ? ST_RUN : ST_INIT;
            end
         end
         ST_INIT:
         begin
            if (pd_req)
            begin
               nxt_state = ST_PWRDN;
            end
            else if (eff_mode == OPM_DUAL || eff_mode == OPM_SINGLE)
            begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN:
         begin
            // no path back to the initial mode except through power-down
            if (pd_req)
            begin
               nxt_state = ST_PWRDN;
            end
         end
         default:
         begin
            nxt_state = ST_PWRDN;
         end
      endcase
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in || pin_pd)
      begin
         state_ff <= ST_PWRDN;
      end
      else if (ce_in)
      begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in || pin_pd)
      begin
         wake_cnt_ff <= 32'h0000_0000;
      end
      else if (ce_in)
      begin
         if (state_ff == ST_WAKE)
         begin
            wake_cnt_ff <= wake_cnt_ff + 32'h0000_0001;
         end
         else
         begin
            wake_cnt_ff <= 32'h0000_0000;
         end
      end
   end

   // noise canceler dropout after bypass is removed; counted in every state except power-down
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in || pin_pd)
      begin
         noise_eff_prev_ff <= 1'b0;
         drop_cnt_ff       <= 32'h0000_0000;
      end
      else if (ce_in)
      begin
         noise_eff_prev_ff <= noise_eff;
         if (state_ff == ST_PWRDN)
         begin
            drop_cnt_ff <= 32'h0000_0000;
         end
         else if (noise_eff_prev_ff && !noise_eff)
         begin
            drop_cnt_ff <= 32'(DROP_CYCLES_P);
         end
         else if (drop_cnt_ff != 32'h0000_0000)
         begin
            drop_cnt_ff <= drop_cnt_ff - 32'h0000_0001;
         end
      end
   end

   // gain decode, identical for both directions
   assign gain_code[0] = rx_level_ff[5:0];
   assign gain_code[1] = tx_level_ff[5:0];

   for (genvar g = 0; g < 2; g++)
   begin : g_gain
      logic signed [7:0] ext;
      assign ext = {{2{gain_code[g][5]}}, gain_code[g]};
      always_ff @(posedge mclk_in)
      begin
         if (!rst_n_in || pin_pd)
         begin
            gain_ff[g] <= '0;
         end
         else if (ce_in)
         begin
            gain_ff[g].mute    <= (gain_code[g] == GAIN_MUTE);
            gain_ff[g].gain_db <= (gain_code[g] == GAIN_MUTE) ? 8'sh00 : ext + ext + ext;
         end
      end
   end

   assign rx_gain_out = gain_ff[0];
   assign tx_gain_out = gain_ff[1];

   // status and path controls
   assign power_down_out    = (state_ff == ST_PWRDN);
   assign initial_mode_out  = (state_ff == ST_INIT);
   assign dual_mode_out     = in_run && (eff_mode == OPM_DUAL);
   assign single_mode_out   = in_run && (eff_mode == OPM_SINGLE);
   assign acoustic_delay_ms_out = dual_mode_out ? DUAL_ACOUSTIC_DELAY_MS : 8'h00;
   assign line_delay_ms_out     = dual_mode_out ? DUAL_LINE_DELAY_MS : 8'h00;
   assign canceler_clear_out    = soft_rst && !power_down_out;
   assign noise_dropout_out     = (drop_cnt_ff != 32'h0000_0000);
   // silence while coefficients clear, during dropout and outside the run modes
   assign audio_mute_out    = soft_rst || noise_dropout_out || !in_run;
   assign echo_canceler_run_out  = (dual_mode_out || single_mode_out) && !soft_rst;
   assign noise_canceler_run_out = in_run && !soft_rst && !noise_eff
                                   && !noise_dropout_out;
   assign noise_through_out = noise_eff;

   assign line_codec_power_out   = !power_down_out && !line_dis_eff;
   assign line_codec_out_oe_out  = line_codec_power_out;
   assign line_codec_in_idle_out = !line_codec_power_out;
   // in external clock mode the clock pins are inputs, so the bit does nothing there
   assign clock_out_oe_out  = !clock_source_select_in && !power_down_out
                              && !mode_ff[B_CLK_DIS];
   assign line_serial_out_oe_out     = in_run && !mode_ff[B_LPORT_DIS];
   assign line_serial_in_idle_out    = !line_serial_out_oe_out;
   assign message_serial_out_oe_out  = in_run && !mode_ff[B_MPORT_DIS];
   assign message_serial_in_idle_out = !message_serial_out_oe_out;
   assign pads_apply_out    = bypass_ff[B_PAD] | pad_bypass_in;
   assign slope_through_out = bypass_ff[B_SLOPE] | slope_bypass_in;

endmodule

// ===== test/vpm_mode_regs_properties.sv
// Port-level assertions for the mode control bank.
// Assumes one clock mclk_in and synchronous active-low rst_n_in.
`timescale 1ns/1ns
module vpm_mode_regs_chk
(
   input wire logic       mclk_in,
   input wire logic       rst_n_in,
   input wire logic       power_down_reset_n_in,
   input wire logic       soft_reset_n_in,
   input wire logic       line_codec_disable_in,
   input wire logic       canceler_select_in,
   input wire logic       pad_bypass_in,
   input wire logic       noise_bypass_in,
   input wire logic       mem_wr_out,
   input wire logic       power_down_out,
   input wire logic       initial_mode_out,
   input wire logic       dual_mode_out,
   input wire logic [7:0] acoustic_delay_ms_out,
   input wire logic [7:0] line_delay_ms_out,
   input wire logic       canceler_clear_out,
   input wire logic       audio_mute_out,
   input wire logic       echo_canceler_run_out,
   input wire logic       noise_canceler_run_out,
   input wire logic       noise_through_out,
   input wire logic       noise_dropout_out,
   input wire logic       line_codec_power_out,
   input wire logic       line_codec_out_oe_out,
   input wire logic       line_codec_in_idle_out,
   input wire logic       line_serial_out_oe_out,
   input wire logic       line_serial_in_idle_out,
   input wire logic       message_serial_out_oe_out,
   input wire logic       message_serial_in_idle_out,
   input wire logic       pads_apply_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   property p_pdn; !power_down_reset_n_in |=> power_down_out; endproperty
   a_pdn: assert property (p_pdn) else $error("power-down pin not obeyed");
   property p_soft; !soft_reset_n_in && !power_down_out |-> ##[0:1] (canceler_clear_out && audio_mute_out); endproperty
   a_soft: assert property (p_soft) else $error("soft reset pin not obeyed");
   property p_codec; line_codec_disable_in |-> !line_codec_power_out && !line_codec_out_oe_out
      && line_codec_in_idle_out; endproperty
   a_codec: assert property (p_codec) else $error("line codec still active");
   property p_init; initial_mode_out |-> !line_serial_out_oe_out && !message_serial_out_oe_out
      && line_serial_in_idle_out && message_serial_in_idle_out && !echo_canceler_run_out
      && !noise_canceler_run_out; endproperty
   a_init: assert property (p_init) else $error("initial mode not quiet");
   property p_delay; dual_mode_out |-> acoustic_delay_ms_out == 8'h2c && line_delay_ms_out == 8'h0f; endproperty
   a_delay: assert property (p_delay) else $error("dual mode delays wrong");
   property p_canceler_select; dual_mode_out |-> !canceler_select_in; endproperty
   a_canceler_select: assert property (p_canceler_select) else $error("canceler select pin not ORed");
   property p_mem; mem_wr_out |-> $past(initial_mode_out) && !initial_mode_out == 1'b0 ##1 !mem_wr_out; endproperty
   a_mem: assert property (p_mem) else $error("memory write outside initial mode");
   property p_pad; pad_bypass_in |-> pads_apply_out; endproperty
   a_pad: assert property (p_pad) else $error("pad pin not ORed");
   property p_noise; noise_bypass_in |-> noise_through_out && !noise_canceler_run_out; endproperty
   a_noise: assert property (p_noise) else $error("noise pin not ORed");
   property p_drop; $fell(noise_through_out) && !power_down_out |-> ##[0:3] noise_dropout_out; endproperty
   a_drop: assert property (p_drop) else $error("no dropout after bypass off");
endmodule
bind vpm_mode_regs vpm_mode_regs_chk u_vpm_mode_regs_chk (.*);

// ===== test/vpm_host_model.sv
// Host microcontroller model: APB master for the mode control bank.
// Assumes the slave shares mclk_in; waits for pready with no fixed count.
`timescale 1ns/1ns
module vpm_host_model
(
   input  wire logic             mclk_in,
   output vpm_pkg::vpm_apb_req_t apb_out,
   input  wire logic [31:0]      prdata_in,
   input  wire logic             pready_in,
   input  wire logic             pslverr_in
);
   import vpm_pkg::*;
   initial apb_out = '0;
   // reserved bits are the caller's choice, so refusals can be tried on purpose
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge mclk_in);
      apb_out <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge mclk_in);
      apb_out.penable <= 1'b1;
      do @(posedge mclk_in); while (pready_in !== 1'b1);
      rd = prdata_in;
      err = pslverr_in;
      apb_out <= '0;
   endtask
endmodule

// ===== test/testbench.sv
// Self-checking bench for the mode control bank.
// Assumes short wake and dropout counts set through parameters.
`timescale 1ns/1ns
module testbench;
   import vpm_pkg::*;
   localparam int WK = 20;
   localparam int DR = 10;
   localparam logic [5:0] GC [5] = '{6'h0a, 6'h00, 6'h3f, 6'h2c, 6'h2b};
   localparam logic [8:0] GE [5] = '{9'h01e, 9'h000, 9'h0fd, 9'h0c4, 9'h100};
   logic mclk_in = 0, rst_n_in = 0, ce_in = 1, power_down_reset_n_in = 1, soft_reset_n_in = 1;
   logic line_codec_disable_in = 0, clock_source_select_in = 0, host_select_in = 0;
   logic canceler_select_in = 0, pad_bypass_in = 0, slope_bypass_in = 0, noise_bypass_in = 0;
   logic [15:0] mem_addr_in = 16'h0000, mem_data_in = 16'h0000, mem_addr_out, mem_data_out;
   logic [31:0] prdata_out, rd;
   logic [7:0] acoustic_delay_ms_out, line_delay_ms_out;
   logic pready_out, pslverr_out, mem_wr_out, power_down_out, initial_mode_out, dual_mode_out;
   logic single_mode_out, canceler_clear_out, audio_mute_out, echo_canceler_run_out;
   logic noise_canceler_run_out, noise_through_out, noise_dropout_out, line_codec_power_out;
   logic line_codec_out_oe_out, line_codec_in_idle_out, clock_out_oe_out, line_serial_out_oe_out;
   logic line_serial_in_idle_out, message_serial_out_oe_out, message_serial_in_idle_out;
   logic pads_apply_out, slope_through_out;
   vpm_gain_t rx_gain_out, tx_gain_out;
   vpm_apb_req_t apb_in;
   int err_total = 0, cmp_count = 0;
   vpm_mode_regs #(.WAKE_CYCLES_P(WK), .DROP_CYCLES_P(DR)) u_vpm_mode_regs (.*);
   vpm_host_model u_vpm_host_model (.mclk_in(mclk_in), .apb_out(apb_in), .prdata_in(prdata_out),
      .pready_in(pready_out), .pslverr_in(pslverr_out));
   initial forever #5 mclk_in = ~mclk_in;
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic e;
      u_vpm_host_model.xfer(1'b1, a, {24'h0, d}, rd, e);
      #1;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
      logic e;
      u_vpm_host_model.xfer(1'b0, a, 32'h0, rd, e);
      chk({e, rd}, {1'b0, 24'h0, exp});
   endtask
   task automatic t_wake(input logic skip);
      int n;
      n = 0;
      while (initial_mode_out !== 1'b1 && n < WK + 9)
      begin
         step(1);
         n++;
      end
      chk(n >= WK && n < WK + 4, !skip);
      if (skip) chk(dual_mode_out, 1'b1);
      else chk({line_serial_out_oe_out, message_serial_out_oe_out, echo_canceler_run_out,
         noise_canceler_run_out, line_serial_in_idle_out, message_serial_in_idle_out}, 6'h03);
   endtask
   task automatic t_regs;
      logic e;
      for (int i = 0; i < 4; i++) rdc(12'(i * 4), 8'h00);
      u_vpm_host_model.xfer(1'b0, 12'h010, 32'h0, rd, e);
      chk({e, rd}, {1'b1, 32'h0});
      @(posedge mclk_in);
      mem_addr_in <= 16'h5a3c;
      mem_data_in <= 16'hc3a5;
      wr(12'h004, 8'h80);
      chk({mem_wr_out, mem_addr_out, mem_data_out}, 33'h15a3cc3a5);
      step(1);
      chk(mem_wr_out, 1'b0);
      rdc(12'h004, 8'h00);
   endtask
   task automatic t_mode;
      wr(12'h000, 8'h2a);
      // the sequencer leaves the initial mode one edge after the mode write lands
      step(1);
      chk({dual_mode_out, initial_mode_out, line_codec_power_out, line_codec_out_oe_out, clock_out_oe_out,
         line_serial_out_oe_out, line_serial_in_idle_out, message_serial_out_oe_out}, 8'h8b);
      chk({acoustic_delay_ms_out, line_delay_ms_out}, 16'h2c0f);
      wr(12'h004, 8'h80);
      chk(mem_wr_out, 1'b0);
      wr(12'h000, 8'h03);
      rdc(12'h000, 8'h2a);
      @(posedge mclk_in) canceler_select_in <= 1'b1;
      step(1);
      chk({single_mode_out, dual_mode_out}, 2'b10);
      @(posedge mclk_in) canceler_select_in <= 1'b0;
   endtask
   task automatic t_gain;
      for (int i = 0; i < 5; i++)
      begin
         wr(12'h008, {2'b00, GC[i]});
         wr(12'h00c, {2'b00, GC[i]});
         step(2);
         chk(rx_gain_out, GE[i]);
         chk(tx_gain_out, GE[i]);
         rdc(12'h008, {2'b00, GC[i]});
      end
      wr(12'h000, 8'h6a);
      chk({canceler_clear_out, audio_mute_out}, 2'b11);
      rdc(12'h008, 8'h2b);
      wr(12'h000, 8'h2a);
      chk(canceler_clear_out, 1'b0);
      @(posedge mclk_in) soft_reset_n_in <= 1'b0;
      step(1);
      chk({canceler_clear_out, audio_mute_out}, 2'b11);
      @(posedge mclk_in) soft_reset_n_in <= 1'b1;
   endtask
   task automatic t_noise;
      int n;
      n = 0;
      @(posedge mclk_in);
      {pad_bypass_in, noise_bypass_in, line_codec_disable_in, slope_bypass_in} <= 4'hf;
      step(2);
      chk({pads_apply_out, noise_through_out, slope_through_out}, 3'b111);
      @(posedge mclk_in);
      {pad_bypass_in, noise_bypass_in, line_codec_disable_in, slope_bypass_in} <= 4'h0;
      step(DR + 5);
      wr(12'h004, 8'h05);
      chk({pads_apply_out, noise_through_out, noise_canceler_run_out}, 3'b110);
      wr(12'h004, 8'h00);
      repeat (DR + 6)
      begin
         step(1);
         if (noise_dropout_out === 1'b1) n++;
      end
      chk(n, DR);
   endtask
   task automatic t_pdown;
      wr(12'h000, 8'h80);
      step(2);
      chk(power_down_out, 1'b1);
      rdc(12'h000, 8'h80);
      rdc(12'h008, 8'h00);
      wr(12'h000, 8'h10);
      t_wake(1'b0);
      chk(clock_out_oe_out, 1'b0);
      @(posedge mclk_in);
      power_down_reset_n_in <= 1'b0;
      host_select_in <= 1'b1;
      step(2);
      chk(power_down_out, 1'b1);
      @(posedge mclk_in) power_down_reset_n_in <= 1'b1;
      t_wake(1'b1);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #60000;
      err_total++;
      tally_and_finish();
   end
   initial
   begin
      repeat (20) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      t_wake(1'b0);
      t_regs();
      $display("reset and memory test done");
      t_mode();
      $display("mode test done");
      t_gain();
      $display("gain test done");
      t_noise();
      $display("bypass test done");
      t_pdown();
      $display("power-down test done");
      tally_and_finish();
   end
endmodule
